/* src/accel_offset_compensation.sv */
// offset compensation datapath for three 12-bit acceleration axes with its registers
// assumes synchronous register strobes and one raw sample per accepted valid
//
// Behaviour
// - compensation derived from unfiltered samples, offset applied to every output stream
// - sum of sample and offset saturates to the 12-bit extremes
// - public 8-bit trim change is widened into the 12-bit internal value
// - internal value change is narrowed with saturation into the public trim
// - image update copies stored bytes into the three trim registers
// - host may write the trim registers at any time except during an image update, which overwrites them
// - writing one to the clear bit zeroes all three trims
// - slow compensation high-pass steers each enabled axis output toward zero
// - cut bit selects high-pass corner bandwidth/1000 or 8x that
// - three slow enable bits, one per axis, in the control register
// - fast trigger averages 16 samples; offset becomes target minus average, saturated
// - trigger field 00 none, 01 x, 10 y, 11 z
// - trigger field is write-only and launches the run
// - done bit reads zero while a fast run is active
// - per-axis target codes 00 0g, 01 +1g, 10 -1g, 11 0g
// - stored trims are loaded after every reset and used until overwritten
// - bandwidth code 01000..01111 maps 7.81 Hz..1000 Hz, doubling each step
// - image update after reset and on a write of the load bit
`timescale 1ns/1ps
`default_nettype none
module accel_offset_compensation (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic [4:0]  filtered_bandwidth_code_i,
	input  wire logic        raw_valid_i,
	output logic             raw_ready_o,
	input  wire logic [11:0] raw_x_i,
	input  wire logic [11:0] raw_y_i,
	input  wire logic [11:0] raw_z_i,
	output logic             comp_valid_o,
	input  wire logic        comp_ready_i,
	output logic      [11:0] comp_x_o,
	output logic      [11:0] comp_y_o,
	output logic      [11:0] comp_z_o
);
	localparam int AX = trim_pkg::AXES;

	logic [2:0]               slow_en_q;
	logic [6:0]               param_q;
	logic [7:0]               rdata_q;
	logic [7:0]               trim_q [AX];
	logic [31:0]              acc_q [AX];
	logic [11:0]              raw_s [AX];
	logic [11:0]              out_s [AX];
	logic [31:0]              hp_next [AX];
	logic [2:0]               bw_idx;
	logic [4:0]               hp_shift;
	trim_pkg::fast_state_t    fast_state_q;
	logic [1:0]               fast_axis_q;
	logic [3:0]               fast_cnt_q;
	logic [15:0]              fast_sum_q;
	logic [15:0]              fast_total;
	logic [11:0]              fast_tgt;
	logic [11:0]              fast_val;
	logic                     fast_done;
	logic                     load_busy_q;
	logic [1:0]               load_idx_q;
	logic                     nvm_pend_q;
	logic [1:0]               nvm_idx_q;
	logic [7:0]               nvm_rdata;
	logic                     sample_acc;
	logic                     wr_ctrl;
	logic                     clear_req;
	logic [1:0]               trig_field;

	function automatic logic [11:0] widen(input logic [7:0] v);
		return {v[7], v, 3'h0};
	endfunction

	function automatic logic [7:0] narrow(input logic [11:0] v);
		if (v[11] && !v[10]) begin
			return 8'h80;
		end else if (!v[11] && v[10]) begin
			return 8'h7F;
		end
		return v[10:3];
	endfunction

	function automatic logic [11:0] sat13(input logic [12:0] v);
		if (v[12] != v[11]) begin
			return v[12] ? 12'h800 : 12'h7FF;
		end
		return v[11:0];
	endfunction

	function automatic logic [31:0] sat33(input logic [32:0] v);
		if (v[32] != v[31]) begin
			return v[32] ? 32'h80000000 : 32'h7FFFFFFF;
		end
		return v[31:0];
	endfunction

	assign raw_s[0]   = raw_x_i;
	assign raw_s[1]   = raw_y_i;
	assign raw_s[2]   = raw_z_i;
	assign wr_ctrl    = reg_wr_i && (reg_addr_i == trim_pkg::ADDR_CTRL);
	assign clear_req  = wr_ctrl && reg_wdata_i[trim_pkg::CTRL_CLEAR_BIT];
	assign trig_field = reg_wdata_i[trim_pkg::CTRL_TRIG_LSB +: 2];

	// sample path through the fifo
	stream_if #(.W(trim_pkg::SAMPLE_W)) samp_if ();

	assign samp_if.valid = raw_valid_i;
	assign samp_if.data  = {out_s[2], out_s[1], out_s[0]};
	assign raw_ready_o   = samp_if.ready;
	assign sample_acc    = raw_valid_i && samp_if.ready;

	stream_fifo #(
		.WIDTH (trim_pkg::SAMPLE_W),
		.DEPTH (trim_pkg::FIFO_DEPTH)
	) u_stream_fifo (
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.push_if     (samp_if),
		.pop_valid_o (comp_valid_o),
		.pop_ready_i (comp_ready_i),
		.pop_data_o  ({comp_z_o, comp_y_o, comp_x_o})
	);

	always_comb begin
		if (filtered_bandwidth_code_i[4]) begin
			bw_idx = trim_pkg::BW_TOP_IDX;
		end else if (!filtered_bandwidth_code_i[3]) begin
			bw_idx = 3'h0;
		end else begin
			bw_idx = filtered_bandwidth_code_i[2:0];
		end
	end

	always_comb begin
		hp_shift = trim_pkg::HP_SHIFT_BASE + {2'h0, trim_pkg::BW_TOP_IDX - bw_idx};
		if (!param_q[trim_pkg::PARAM_CUT_BIT]) begin
			hp_shift = hp_shift + trim_pkg::HP_CUT_SHIFT;
		end
	end

	// stored trim store
	nvm_image_store #(
		.W    (trim_pkg::TRIM_W),
		.N    (trim_pkg::NVM_WORDS),
		.INIT (trim_pkg::NVM_INIT)
	) u_nvm_image_store (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.rd_en_i   (load_busy_q),
		.rd_addr_i (load_idx_q),
		.rd_data_o (nvm_rdata)
	);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			load_busy_q <= trim_pkg::LOAD_BUSY_RST;
			load_idx_q  <= 2'h0;
			nvm_pend_q  <= 1'b0;
			nvm_idx_q   <= 2'h0;
		end else begin
			nvm_pend_q <= load_busy_q;
			nvm_idx_q  <= load_idx_q;
			if (load_busy_q) begin
				load_idx_q <= load_idx_q + 2'h1;
				if (load_idx_q == 2'(trim_pkg::NVM_WORDS - 1)) begin
					load_busy_q <= 1'b0;
					load_idx_q  <= 2'h0;
				end
			end else if (reg_wr_i && (reg_addr_i == trim_pkg::ADDR_NVM_CTRL)
					&& reg_wdata_i[trim_pkg::NVM_LOAD_BIT]) begin
				load_busy_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slow_en_q <= trim_pkg::CTRL_EN_RST;
			param_q   <= trim_pkg::PARAM_RST;
		end else begin
			if (wr_ctrl) begin
				slow_en_q <= reg_wdata_i[2:0];
			end
			if (reg_wr_i && (reg_addr_i == trim_pkg::ADDR_PARAM)) begin
				param_q <= reg_wdata_i[6:0];
			end
		end
	end

	always_comb begin
		unique case (param_q[trim_pkg::PARAM_TGT_LSB + 2*fast_axis_q +: 2])
			trim_pkg::TGT_POS: fast_tgt = trim_pkg::TARGET_POS;
			trim_pkg::TGT_NEG: fast_tgt = trim_pkg::TARGET_NEG;
			default:           fast_tgt = trim_pkg::TARGET_ZERO;
		endcase
	end

	// average of 16 raw samples, target minus average
	assign fast_total = fast_sum_q + {{4{raw_s[fast_axis_q][11]}}, raw_s[fast_axis_q]};
	assign fast_val   = sat13({fast_tgt[11], fast_tgt} - {fast_total[15], fast_total[15:4]});
	assign fast_done  = (fast_state_q == trim_pkg::FAST_RUN) && sample_acc
		&& (fast_cnt_q == trim_pkg::FAST_LAST);

	// write launches, nothing stored for readback
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fast_state_q <= trim_pkg::FAST_IDLE;
			fast_axis_q  <= 2'h0;
			fast_cnt_q   <= 4'h0;
			fast_sum_q   <= 16'h0000;
		end else begin
			unique case (fast_state_q)
				trim_pkg::FAST_IDLE: begin
					if (wr_ctrl && (trig_field != trim_pkg::TRIG_NONE)) begin
						fast_state_q <= trim_pkg::FAST_RUN;
						fast_axis_q  <= trig_field - 2'h1;
						fast_cnt_q   <= 4'h0;
						fast_sum_q   <= 16'h0000;
					end
				end
				trim_pkg::FAST_RUN: begin
					if (sample_acc) begin
						fast_sum_q <= fast_total;
						fast_cnt_q <= fast_cnt_q + 4'h1;
						if (fast_done) begin
							fast_state_q <= trim_pkg::FAST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// per-axis offset and trim
	for (genvar a = 0; a < AX; a++) begin : g_axis
		logic [32:0] hp_diff;
		logic [31:0] hp_delta;
		logic        own_fast;

		// offset added before output and filtering
		assign out_s[a]  = sat13({raw_s[a][11], raw_s[a]} + {acc_q[a][31], acc_q[a][31:20]});
		// slow update from unfiltered compensated output
		assign hp_delta  = $signed({out_s[a], 20'h00000}) >>> hp_shift;
		assign hp_diff   = {acc_q[a][31], acc_q[a]} - {hp_delta[31], hp_delta};
		assign hp_next[a] = sat33(hp_diff);
		assign own_fast  = fast_done && (fast_axis_q == 2'(a));

		always_ff @(posedge mclk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				acc_q[a]  <= 32'h00000000;
				trim_q[a] <= 8'h00;
			end else if (clear_req) begin
				acc_q[a]  <= 32'h00000000;
				trim_q[a] <= 8'h00;
			end else if (nvm_pend_q && (nvm_idx_q == 2'(a))) begin
				acc_q[a]  <= {widen(nvm_rdata), 20'h00000};
				trim_q[a] <= nvm_rdata;
			end else if (reg_wr_i && (reg_addr_i == trim_pkg::ADDR_TRIM_X + 8'(a))) begin
				acc_q[a]  <= {widen(reg_wdata_i), 20'h00000};
				trim_q[a] <= reg_wdata_i;
			end else if (own_fast) begin
				acc_q[a]  <= {fast_val, 20'h00000};
				trim_q[a] <= narrow(fast_val);
			end else if (sample_acc && slow_en_q[a]) begin
				acc_q[a]  <= hp_next[a];
				trim_q[a] <= narrow(hp_next[a][31:20]);
			end
		end
	end

	// register read port, unmapped reads as zero
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				trim_pkg::ADDR_NVM_CTRL: rdata_q <= {4'h0, load_busy_q, 3'h0};
				trim_pkg::ADDR_CTRL:     rdata_q <= {3'h0,
					fast_state_q == trim_pkg::FAST_IDLE, 1'b0, slow_en_q};
				trim_pkg::ADDR_PARAM:    rdata_q <= {1'b0, param_q};
				trim_pkg::ADDR_TRIM_X:   rdata_q <= trim_q[0];
				trim_pkg::ADDR_TRIM_Y:   rdata_q <= trim_q[1];
				trim_pkg::ADDR_TRIM_Z:   rdata_q <= trim_q[2];
				default:                 rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;
endmodule
`default_nettype wire

/* inc/trim_pkg.sv */
// constants, register map and types of the acceleration offset compensation block
// assumes an 8-bit register port and 12-bit two's complement samples
`default_nettype none
package trim_pkg;
	localparam int AXES       = 3;
	localparam int DATA_W     = 12;
	localparam int TRIM_W     = 8;
	localparam int SAMPLE_W   = 36;
	localparam int FIFO_DEPTH = 16;
	localparam int FRAC_W     = 20;
	localparam int ACC_W      = 32;
	localparam int SUM_W      = 16;
	localparam int NVM_WORDS  = 3;

	// register byte addresses
	localparam logic [7:0] ADDR_NVM_CTRL = 8'h33;
	localparam logic [7:0] ADDR_CTRL     = 8'h36;
	localparam logic [7:0] ADDR_PARAM    = 8'h37;
	localparam logic [7:0] ADDR_TRIM_X   = 8'h38;
	localparam logic [7:0] ADDR_TRIM_Y   = 8'h39;
	localparam logic [7:0] ADDR_TRIM_Z   = 8'h3A;

	// field positions
	localparam int NVM_LOAD_BIT   = 3;
	localparam int CTRL_CLEAR_BIT = 7;
	localparam int CTRL_TRIG_LSB  = 5;
	localparam int CTRL_RDY_BIT   = 4;
	localparam int PARAM_CUT_BIT  = 0;
	localparam int PARAM_TGT_LSB  = 1;

	// values after reset
	localparam logic [2:0] CTRL_EN_RST   = 3'h0;
	localparam logic [6:0] PARAM_RST     = 7'h00;
	localparam logic       LOAD_BUSY_RST = 1'b1;

	// fast compensation
	localparam logic [3:0]  FAST_LAST   = 4'hF;
	localparam logic [1:0]  TRIG_NONE   = 2'h0;
	localparam logic [1:0]  TGT_POS     = 2'h1;
	localparam logic [1:0]  TGT_NEG     = 2'h2;
	localparam logic [11:0] TARGET_POS  = 12'h400;
	localparam logic [11:0] TARGET_NEG  = 12'hC00;
	localparam logic [11:0] TARGET_ZERO = 12'h000;

	// slow compensation step size: shift = base + (top - band index) + cut term
	localparam logic [4:0] HP_SHIFT_BASE = 5'h08;
	localparam logic [4:0] HP_CUT_SHIFT  = 5'h03;
	localparam logic [2:0] BW_TOP_IDX    = 3'h7;

	// stored trim bytes, arbitrary contents, nonzero so an image load is visible
	localparam logic [23:0] NVM_INIT = 24'h1A2B3C;

	typedef enum logic {
		FAST_IDLE = 1'b0,
		FAST_RUN  = 1'b1
	} fast_state_t;
endpackage
`default_nettype wire

/* inc/stream_if.sv */
// valid/ready carrier for compensated samples between the datapath and its fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 36);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/nvm_image_store.sv */
// small read-only store holding the trim bytes loaded at each image update
// assumes one read per cycle; data appear one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module nvm_image_store #(
	parameter int              W     = 8,
	parameter int              N     = 3,
	parameter logic [N*W-1:0]  INIT  = '0
) (
	input  wire logic                 mclk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 rd_en_i,
	input  wire logic [1:0]           rd_addr_i,
	output logic      [W-1:0]         rd_data_o
);
	logic [W-1:0] rd_data_q;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_q <= '0;
		end else if (rd_en_i) begin
			rd_data_q <= INIT[rd_addr_i*W +: W];
		end
	end

	assign rd_data_o = rd_data_q;
endmodule
`default_nettype wire

/* src/stream_fifo.sv */
// first-in first-out buffer for compensated samples
// assumes the drain side may stall; ready drops when full
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk_i,
	input  wire logic             nrst_i,
	stream_if.sink                push_if,
	output logic                  pop_valid_o,
	input  wire logic             pop_ready_i,
	output logic [WIDTH-1:0]      pop_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [CW-1:0]    count_q;
	logic             push;
	logic             pop;

	assign push_if.ready = (count_q != CW'(DEPTH));
	assign pop_valid_o   = (count_q != '0);
	assign push          = push_if.valid && push_if.ready;
	assign pop           = pop_valid_o && pop_ready_i;
	assign pop_data_o    = mem_q[rd_ptr_q];

	// storage
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= push_if.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + PW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + PW'(1);
			end
			if (push && !pop) begin
				count_q <= count_q + CW'(1);
			end else if (pop && !push) begin
				count_q <= count_q - CW'(1);
			end
		end
	end
endmodule
`default_nettype wire

/* tb/accel_offset_compensation_chk.sv */
// assertions on the ports of the offset compensation block
// assumes trim_pkg is compiled first; bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module accel_offset_compensation_chk (
	input wire logic        mclk_i,
	input wire logic        nrst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic [4:0]  filtered_bandwidth_code_i,
	input wire logic        raw_valid_i,
	input wire logic        raw_ready_o,
	input wire logic [11:0] raw_x_i,
	input wire logic [11:0] raw_y_i,
	input wire logic [11:0] raw_z_i,
	input wire logic        comp_valid_o,
	input wire logic        comp_ready_i,
	input wire logic [11:0] comp_x_o,
	input wire logic [11:0] comp_y_o,
	input wire logic [11:0] comp_z_o
);
	logic [4:0] fill_q;
	logic [3:0] quiet_q;
	logic       trim_adr;
	logic       mapped;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	assign trim_adr = reg_addr_i >= trim_pkg::ADDR_TRIM_X && reg_addr_i <= trim_pkg::ADDR_TRIM_Z;
	assign mapped   = trim_adr || reg_addr_i == trim_pkg::ADDR_NVM_CTRL
		|| reg_addr_i == trim_pkg::ADDR_CTRL || reg_addr_i == trim_pkg::ADDR_PARAM;

	// words held by the fifo
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fill_q <= 5'h00;
		end else begin
			fill_q <= fill_q + 5'(raw_valid_i && raw_ready_o) - 5'(comp_valid_o && comp_ready_i);
		end
	end

	// cycles since reset or any write to the image control register, held at 15
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quiet_q <= 4'h0;
		end else if (reg_wr_i && reg_addr_i == trim_pkg::ADDR_NVM_CTRL) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hF) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end

	sequence s_trim_wr;
		reg_wr_i && trim_adr && quiet_q == 4'hF;
	endsequence
	sequence s_clear_wr;
		reg_wr_i && reg_addr_i == trim_pkg::ADDR_CTRL && reg_wdata_i[7] && quiet_q == 4'hF;
	endsequence
	sequence s_trig_wr;
		reg_wr_i && reg_addr_i == trim_pkg::ADDR_CTRL && reg_wdata_i[6:5] != 2'h0 && !raw_valid_i;
	endsequence

	a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_wo_bits: assert property (
		reg_rd_i && reg_addr_i == trim_pkg::ADDR_CTRL |=> reg_rdata_o[7:5] == 3'h0)
		else $error("write-only control bits read back");
	a_trim_readback: assert property (
		s_trim_wr ##1 !raw_valid_i && !reg_wr_i ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2)
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("trim write not read back");
	a_clear_zero: assert property (
		s_clear_wr ##1 !raw_valid_i && !reg_wr_i ##1 reg_rd_i && trim_adr |=> reg_rdata_o == 8'h00)
		else $error("trim not cleared");
	a_done_low: assert property (
		s_trig_wr ##1 !raw_valid_i ##1 reg_rd_i && reg_addr_i == trim_pkg::ADDR_CTRL
		|=> !reg_rdata_o[trim_pkg::CTRL_RDY_BIT])
		else $error("done high during fast run");
	a_full_ready: assert property (raw_ready_o == (fill_q != 5'h10))
		else $error("input ready disagrees with fill");
	a_valid_fill: assert property (comp_valid_o == (fill_q != 5'h00))
		else $error("output valid disagrees with fill");
	a_head_stable: assert property (comp_valid_o && !comp_ready_i
		|=> comp_valid_o && $stable(comp_x_o) && $stable(comp_y_o) && $stable(comp_z_o))
		else $error("stalled head changed");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without read");
endmodule

bind accel_offset_compensation accel_offset_compensation_chk u_accel_offset_compensation_chk (
	.mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.filtered_bandwidth_code_i, .raw_valid_i, .raw_ready_o, .raw_x_i, .raw_y_i, .raw_z_i,
	.comp_valid_o, .comp_ready_i, .comp_x_o, .comp_y_o, .comp_z_o
);
`default_nettype wire

/* tb/tb_accel_offset_compensation.sv */
// self-checking bench for the offset compensation block
// assumes trim_pkg, stream_if and the design are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_accel_offset_compensation;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [7:0]  reg_rdata_o;
	logic [4:0]  filtered_bandwidth_code_i = 5'h0F;
	logic        raw_valid_i = 1'b0;
	logic        raw_ready_o;
	logic [11:0] raw_x_i = 12'h000;
	logic [11:0] raw_y_i = 12'h000;
	logic [11:0] raw_z_i = 12'h000;
	logic        comp_valid_o;
	logic        comp_ready_i = 1'b0;
	logic [11:0] comp_x_o;
	logic [11:0] comp_y_o;
	logic [11:0] comp_z_o;
	logic [7:0]  rv;
	int          num_errors = 0;
	int          cmp_count = 0;

	always #10 mclk_i = ~mclk_i;

	accel_offset_compensation u_accel_offset_compensation (
		.mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.filtered_bandwidth_code_i, .raw_valid_i, .raw_ready_o, .raw_x_i, .raw_y_i, .raw_z_i,
		.comp_valid_o, .comp_ready_i, .comp_x_o, .comp_y_o, .comp_z_o
	);

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] comp(input logic [11:0] r, input logic [7:0] t);
		int s;
		s = $signed(r) + $signed(t) * 8;
		s = (s > 2047) ? 2047 : ((s < -2048) ? -2048 : s);
		return s[11:0];
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge mclk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		rv = reg_rdata_o;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk({4'h0, rv}, {4'h0, e});
	endtask

	task automatic push(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		@(negedge mclk_i);
		raw_x_i = x;
		raw_y_i = y;
		raw_z_i = z;
		raw_valid_i = 1'b1;
		while (raw_ready_o !== 1'b1) @(negedge mclk_i);
		@(negedge mclk_i);
		raw_valid_i = 1'b0;
	endtask

	task automatic pop_chk(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		@(negedge mclk_i);
		chk({11'h000, comp_valid_o}, 12'h001);
		chk(comp_x_o, x);
		chk(comp_y_o, y);
		chk(comp_z_o, z);
		comp_ready_i = 1'b1;
		@(negedge mclk_i);
		comp_ready_i = 1'b0;
	endtask

	task automatic t_reset();
		rd_chk(trim_pkg::ADDR_CTRL, 8'h10);
		rd_chk(trim_pkg::ADDR_PARAM, 8'h00);
		rd_chk(trim_pkg::ADDR_TRIM_X, trim_pkg::NVM_INIT[7:0]);
		rd_chk(trim_pkg::ADDR_TRIM_Z, trim_pkg::NVM_INIT[23:16]);
		rd_chk(8'h34, 8'h00);
	endtask

	task automatic t_manual();
		wr(trim_pkg::ADDR_TRIM_X, 8'h10);
		wr(trim_pkg::ADDR_TRIM_Y, 8'h80);
		wr(trim_pkg::ADDR_TRIM_Z, 8'h7F);
		rd_chk(trim_pkg::ADDR_TRIM_Z, 8'h7F);
		rd_chk(trim_pkg::ADDR_TRIM_Y, 8'h80);
		for (int i = 0; i < 16; i++) begin
			push(12'h7F0, 12'h900, 12'(i * 16));
		end
		chk({11'h000, raw_ready_o}, 12'h000);
		for (int i = 0; i < 16; i++) begin
			pop_chk(comp(12'h7F0, 8'h10), comp(12'h900, 8'h80), comp(12'(i * 16), 8'h7F));
		end
		chk({11'h000, comp_valid_o}, 12'h000);
	endtask

	task automatic t_clear();
		wr(trim_pkg::ADDR_CTRL, 8'h80);
		rd_chk(trim_pkg::ADDR_TRIM_X, 8'h00);
		rd_chk(trim_pkg::ADDR_TRIM_Y, 8'h00);
		rd_chk(trim_pkg::ADDR_TRIM_Z, 8'h00);
	endtask

	task automatic t_fast();
		logic [7:0] e [4] = '{8'hE0, 8'h60, 8'h80, 8'hE0};
		logic [1:0] c;
		comp_ready_i = 1'b1;
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			wr(trim_pkg::ADDR_PARAM, {1'b0, c, c, c, 1'b0});
			wr(trim_pkg::ADDR_CTRL, {1'b0, 2'(k % 3 + 1), 5'h00});
			rd_chk(trim_pkg::ADDR_CTRL, 8'h00);
			repeat (15) push(12'h100, 12'h100, 12'h100);
			rd_chk(trim_pkg::ADDR_CTRL, 8'h00);
			push(12'h100, 12'h100, 12'h100);
			repeat (2) @(negedge mclk_i);
			rd_chk(trim_pkg::ADDR_CTRL, 8'h10);
			rd_chk(8'(trim_pkg::ADDR_TRIM_X + k % 3), e[k]);
		end
		wr(trim_pkg::ADDR_CTRL, 8'h00);
		rd_chk(trim_pkg::ADDR_CTRL, 8'h10);
		comp_ready_i = 1'b0;
	endtask

	task automatic t_slow();
		logic signed [7:0] s [4];
		comp_ready_i = 1'b1;
		for (int c = 0; c < 4; c++) begin
			filtered_bandwidth_code_i = (c == 2) ? 5'h0E : ((c == 3) ? 5'h10 : 5'h0F);
			wr(trim_pkg::ADDR_CTRL, 8'h80);
			wr(trim_pkg::ADDR_PARAM, {7'h00, c != 1});
			wr(trim_pkg::ADDR_CTRL, 8'h01);
			repeat (64) push(12'h100, 12'h100, 12'h100);
			wr(trim_pkg::ADDR_CTRL, 8'h00);
			rd(trim_pkg::ADDR_TRIM_X);
			s[c] = rv;
			rd_chk(trim_pkg::ADDR_TRIM_Y, 8'h00);
		end
		filtered_bandwidth_code_i = 5'h0F;
		cmp_count++;
		if ((s[0] < s[1] && s[1] < 0 && s[0] > -32) !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t slow trims %h %h", $time, s[0], s[1]);
		end
		cmp_count++;
		if ((s[0] < s[2] && s[2] < s[1] && s[3] == s[0]) !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t band trims %h %h", $time, s[2], s[3]);
		end
		comp_ready_i = 1'b0;
	endtask

	task automatic t_image();
		wr(trim_pkg::ADDR_TRIM_X, 8'h11);
		wr(trim_pkg::ADDR_TRIM_Z, 8'h33);
		wr(trim_pkg::ADDR_NVM_CTRL, 8'h08);
		repeat (8) @(negedge mclk_i);
		rd_chk(trim_pkg::ADDR_TRIM_X, trim_pkg::NVM_INIT[7:0]);
		rd_chk(trim_pkg::ADDR_TRIM_Z, trim_pkg::NVM_INIT[23:16]);
		rd_chk(trim_pkg::ADDR_NVM_CTRL, 8'h00);
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge mclk_i);
		nrst_i = 1'b1;
		repeat (8) @(negedge mclk_i);
		t_reset();
		t_manual();
		t_clear();
		t_fast();
		t_slow();
		t_image();
		report_and_stop();
	end

	initial begin
		#(20 * 20000);
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
